// ---- tqx_cmb_partner.sv ----
`timescale 1ns/1ps
// behavioural stand-in for the other instruments on the shared bus
module tqx_cmb_partner (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic strobe_i,
  input wire logic [7:0] hold_i,
  input wire logic trig_line_i,
  output logic exec_oe_o,
  output logic trig_oe_o
);
  logic [7:0] ecnt_q;
  logic [7:0] tcnt_q;
  logic low_q;
  // active-low execute strobe
  // three cycles long so the far synchroniser cannot miss it
  // hold trigger then release
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ecnt_q <= 8'h00;
      tcnt_q <= 8'h00;
      low_q <= 1'b0;
    end else begin
      if (strobe_i) begin
        ecnt_q <= 8'h03;
      end else if (ecnt_q != 8'h00) begin
        ecnt_q <= ecnt_q - 8'h01;
      end
      if (tcnt_q != 8'h00) begin
        tcnt_q <= tcnt_q - 8'h01;
      end else if (!trig_line_i && !low_q) begin
        tcnt_q <= hold_i;
      end
      low_q <= !trig_line_i;
    end
  end
  // pins only pull low, the pull-up is resolved in the bench
  assign exec_oe_o = ecnt_q != 8'h00;
  assign trig_oe_o = tcnt_q != 8'h00;
endmodule

// ---- tqx_pkg.sv ----
package tqx_pkg;

  // analyzer sample and pattern bank
  localparam int SAMPLE_W = 32;
  localparam int NUM_PATTERNS = 8;
  localparam int NUM_TERMS = 8;
  localparam int TERM_W = 3;
  localparam int QUAL_W = 9;
  localparam int QUAL_ALL_BIT = 8;
  localparam logic [QUAL_W-1:0] QUAL_ALL = 9'h100;

  // register byte offsets, avalon address is a byte address
  localparam int ADDR_W = 7;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 7'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 7'h04;
  localparam logic [ADDR_W-1:0] OFF_EASY_QUAL = 7'h08;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL_QUAL = 7'h0C;
  localparam logic [ADDR_W-1:0] OFF_TRIG_COND = 7'h10;
  localparam logic [ADDR_W-1:0] OFF_RUN_ADDR = 7'h14;
  localparam logic [1:0] AREA_TERM = 2'h1;
  localparam logic [0:0] AREA_PAT = 1'h1;

  // control register fields
  localparam int CTRL_COMPLEX = 0;
  localparam int CTRL_TX_EN = 1;
  localparam int CTRL_COORD_EN = 2;
  localparam int CTRL_ISSUE = 3;
  localparam int CTRL_INTERNAL_TRIGGER_ONE = 4;
  localparam int CTRL_INTERNAL_TRIGGER_TWO = 5;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int EXEC_PULSE_NS = 100;
  localparam int EXEC_PULSE_CYC = (EXEC_PULSE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam logic [7:0] TRIG_HOLD_CYC = 8'h01;
  localparam logic [7:0] SETTLE_CYC = 8'h03;

  typedef enum logic [1:0] {
    TQX_IDLE = 2'b00,
    TQX_DRIVE = 2'b01,
    TQX_SETTLE = 2'b10,
    TQX_WAIT_REL = 2'b11
  } tqx_cmb_state_type;

  // open-drain pin as driven by the block
  typedef struct packed {
    logic out;
    logic oe;
  } tqx_od_type;

  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic complex_mode;
    logic tx_en;
    logic coord_en;
    logic internal_trigger_one;
    logic internal_trigger_two;
    logic [QUAL_W-1:0] easy_qual;
    logic [NUM_TERMS-1:0][QUAL_W-1:0] term_qual;
    logic [QUAL_W-1:0] trigger_condition;
    logic [31:0] run_addr;
    logic [NUM_PATTERNS-1:0][SAMPLE_W-1:0] pat_val;
    logic [NUM_PATTERNS-1:0][SAMPLE_W-1:0] pat_msk;
    logic [1:0] exec_sync;
    logic [1:0] trig_sync;
    logic exec_prev;
    tqx_cmb_state_type st;
    logic [7:0] cnt;
    logic [7:0] exec_cnt;
    logic store;
    logic meas_start;
    logic brk;
    tqx_od_type exec_pin;
    tqx_od_type trig_pin;
  } tqx_state_type;

endpackage

// ---- tqx_store_exec.sv ----
`timescale 1ns/1ps
// Functional notes
// - eight patterns each compare masked sample
// - qualifier ORs its selected patterns
// - reset sets qualifiers to store all
// - mode change restores store-all qualifiers
// - easy mode uses one global qualifier
// - term qualifier acts only in term
// - global write loads all term qualifiers
// - passed terms no longer cause storage
// - trigger condition write keeps qualifiers
// - execute strobe starts measurement when enabled
// - disabled trace-on-execute ignores strobe
// - trace-on-execute enabled after reset
// - drive shared trigger on execute
// - start at once without internal triggers
// - release trigger, wait for all released
// - start internal-trigger analyzers on release
// - issue command pulses execute line
// - coordinated execute breaks, runs at address
// - issuing works regardless of enables
// - complex mode has eight terms
module tqx_store_exec #(
  parameter int EXEC_PULSE_CYC = tqx_pkg::EXEC_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [tqx_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [tqx_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic [tqx_pkg::TERM_W-1:0] seq_term_i,
  output logic store_o,
  output logic meas_start_o,
  output logic break_o,
  output logic [31:0] run_addr_o,
  input wire logic cmb_exec_n_i,
  output tqx_pkg::tqx_od_type cmb_exec_n_o,
  input wire logic cmb_trig_n_i,
  output tqx_pkg::tqx_od_type cmb_trig_n_o
);

  localparam int EXEC_MAX = EXEC_PULSE_CYC + 1;
  localparam int HOLD_MAX = 2;
  localparam logic [7:0] EXEC_LOAD = EXEC_PULSE_CYC[7:0];

  // eight terms; the pulse counter is only 8 bits wide
  if (EXEC_PULSE_CYC < 1 || EXEC_PULSE_CYC > 255) begin : g_pulse
    $error("EXEC_PULSE_CYC must be 1..255");
  end
  if (tqx_pkg::NUM_TERMS != 8 || tqx_pkg::NUM_PATTERNS != 8) begin : g_cnt
    $error("term and pattern counts must be eight");
  end

  tqx_pkg::tqx_state_type s_q;
  tqx_pkg::tqx_state_type s_d;
  logic req;
  logic bus_do;
  logic [31:0] wdata;
  logic [tqx_pkg::NUM_PATTERNS-1:0] match;
  logic hit;
  logic exec_fall;
  logic mode_chg;

  // byte lanes not enabled keep the old contents
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // qualifier: store-all bit, else OR of selected pattern hits
  // OR of patterns
  function automatic logic qual_hit(
      input logic [tqx_pkg::QUAL_W-1:0] q,
      input logic [tqx_pkg::NUM_PATTERNS-1:0] m);
    return q[tqx_pkg::QUAL_ALL_BIT] |
           (|(q[tqx_pkg::NUM_PATTERNS-1:0] & m));
  endfunction

  function automatic tqx_pkg::tqx_state_type reset_state();
    tqx_pkg::tqx_state_type r;
    r = '0;
    r.wait_req = 1'b1;
    r.tx_en = 1'b1;
    r.easy_qual = tqx_pkg::QUAL_ALL;
    for (int t = 0; t < tqx_pkg::NUM_TERMS; t++) begin
      r.term_qual[t] = tqx_pkg::QUAL_ALL;
    end
    r.exec_sync = 2'h3;
    r.trig_sync = 2'h3;
    r.exec_prev = 1'b1;
    r.st = tqx_pkg::TQX_IDLE;
    return r;
  endfunction

  // per-pattern masked compare, mask bit set means care
  always_comb begin
    for (int k = 0; k < tqx_pkg::NUM_PATTERNS; k++) begin
      match[k] = ((sample_i ^ s_q.pat_val[k]) & s_q.pat_msk[k]) == '0;
    end
  end

  assign req = avs_read_i | avs_write_i;
  assign bus_do = req & ~s_q.wait_req;
  assign wdata = avs_writedata_i;
  // falling edge seen only past the second sync stage
  assign exec_fall = s_q.exec_prev & ~s_q.exec_sync[1];
  assign mode_chg = bus_do & avs_write_i & avs_byteenable_i[0] &
                    (avs_address_i == tqx_pkg::OFF_CTRL) &
                    (wdata[tqx_pkg::CTRL_COMPLEX] != s_q.complex_mode);

  // easy mode ignores the active term
  // complex mode uses the qualifier of the current term only
  // an already passed term is not selected any more
  assign hit = s_q.complex_mode ? qual_hit(s_q.term_qual[seq_term_i], match)
                                : qual_hit(s_q.easy_qual, match);

  // next-state logic: bus slave, qualifiers, execute handling
  always_comb begin
    logic [31:0] m;
    m = '0;
    s_d = s_q;
    s_d.meas_start = 1'b0;
    s_d.brk = 1'b0;
    s_d.exec_sync = {s_q.exec_sync[0], cmb_exec_n_i};
    s_d.trig_sync = {s_q.trig_sync[0], cmb_trig_n_i};
    s_d.exec_prev = s_q.exec_sync[1];
    s_d.store = sample_valid_i & hit;

    // one wait cycle, then a single ready cycle with read data
    s_d.wait_req = ~(req & s_q.wait_req);
    if (req && s_q.wait_req) begin
      s_d.rdata = '0;
      unique0 case (avs_address_i)
        tqx_pkg::OFF_CTRL: begin
          s_d.rdata[tqx_pkg::CTRL_COMPLEX] = s_q.complex_mode;
          s_d.rdata[tqx_pkg::CTRL_TX_EN] = s_q.tx_en;
          s_d.rdata[tqx_pkg::CTRL_COORD_EN] = s_q.coord_en;
          s_d.rdata[tqx_pkg::CTRL_INTERNAL_TRIGGER_ONE] = s_q.internal_trigger_one;
          s_d.rdata[tqx_pkg::CTRL_INTERNAL_TRIGGER_TWO] = s_q.internal_trigger_two;
        end
        tqx_pkg::OFF_STATUS:
          s_d.rdata[5:0] = {s_q.trig_sync[1], s_q.exec_sync[1],
                            s_q.exec_pin.oe, s_q.trig_pin.oe, s_q.st};
        tqx_pkg::OFF_EASY_QUAL:
          s_d.rdata[tqx_pkg::QUAL_W-1:0] = s_q.easy_qual;
        tqx_pkg::OFF_TRIG_COND:
          s_d.rdata[tqx_pkg::QUAL_W-1:0] = s_q.trigger_condition;
        tqx_pkg::OFF_RUN_ADDR:
          s_d.rdata = s_q.run_addr;
        default: begin
          if (avs_address_i[6] == tqx_pkg::AREA_PAT) begin
            s_d.rdata = avs_address_i[2] ? s_q.pat_msk[avs_address_i[5:3]]
                                         : s_q.pat_val[avs_address_i[5:3]];
          end else if (avs_address_i[6:5] == tqx_pkg::AREA_TERM) begin
            s_d.rdata[tqx_pkg::QUAL_W-1:0] =
              s_q.term_qual[avs_address_i[4:2]];
          end
        end
      endcase
    end

    // register writes take effect on the ready cycle; unmapped ignored
    if (bus_do && avs_write_i) begin
      unique0 case (avs_address_i)
        tqx_pkg::OFF_CTRL: begin
          if (avs_byteenable_i[0]) begin
            s_d.complex_mode = wdata[tqx_pkg::CTRL_COMPLEX];
            s_d.tx_en = wdata[tqx_pkg::CTRL_TX_EN];
            s_d.coord_en = wdata[tqx_pkg::CTRL_COORD_EN];
            s_d.internal_trigger_one = wdata[tqx_pkg::CTRL_INTERNAL_TRIGGER_ONE];
            s_d.internal_trigger_two = wdata[tqx_pkg::CTRL_INTERNAL_TRIGGER_TWO];
            if (wdata[tqx_pkg::CTRL_ISSUE] && s_q.exec_cnt == '0) begin
              s_d.exec_cnt = EXEC_LOAD;
              s_d.exec_pin.oe = 1'b1;
            end
          end
        end
        tqx_pkg::OFF_EASY_QUAL: begin
          m = be_merge({23'h0, s_q.easy_qual}, wdata, avs_byteenable_i);
          s_d.easy_qual = m[tqx_pkg::QUAL_W-1:0];
        end
        tqx_pkg::OFF_GLOBAL_QUAL: begin
          m = be_merge({23'h0, tqx_pkg::QUAL_ALL}, wdata, avs_byteenable_i);
          // a global qualifier is copied into every term
          for (int t = 0; t < tqx_pkg::NUM_TERMS; t++) begin
            s_d.term_qual[t] = m[tqx_pkg::QUAL_W-1:0];
          end
        end
        // only the trigger condition changes, qualifiers stay
        tqx_pkg::OFF_TRIG_COND: begin
          m = be_merge({23'h0, s_q.trigger_condition}, wdata,
                       avs_byteenable_i);
          s_d.trigger_condition = m[tqx_pkg::QUAL_W-1:0];
        end
        tqx_pkg::OFF_RUN_ADDR:
          s_d.run_addr = be_merge(s_q.run_addr, wdata, avs_byteenable_i);
        default: begin
          if (avs_address_i[6] == tqx_pkg::AREA_PAT) begin
            if (avs_address_i[2]) begin
              s_d.pat_msk[avs_address_i[5:3]] = be_merge(
                s_q.pat_msk[avs_address_i[5:3]], wdata, avs_byteenable_i);
            end else begin
              s_d.pat_val[avs_address_i[5:3]] = be_merge(
                s_q.pat_val[avs_address_i[5:3]], wdata, avs_byteenable_i);
            end
          end else if (avs_address_i[6:5] == tqx_pkg::AREA_TERM) begin
            m = be_merge({23'h0, s_q.term_qual[avs_address_i[4:2]]},
                         wdata, avs_byteenable_i);
            s_d.term_qual[avs_address_i[4:2]] = m[tqx_pkg::QUAL_W-1:0];
          end
        end
      endcase
    end

    // a mode switch overrides any qualifier written with it
    if (mode_chg) begin
      s_d.easy_qual = tqx_pkg::QUAL_ALL;
      for (int t = 0; t < tqx_pkg::NUM_TERMS; t++) begin
        s_d.term_qual[t] = tqx_pkg::QUAL_ALL;
      end
    end

    // execute pulse length counter, line released at the end
    if (s_q.exec_cnt != '0) begin
      s_d.exec_cnt = s_q.exec_cnt - 8'h01;
      s_d.exec_pin.oe = (s_q.exec_cnt != 8'h01);
    end

    // coordinated execute breaks, then runs from run_addr
    if (exec_fall && s_q.coord_en) begin
      s_d.brk = 1'b1;
    end

    // shared trigger handshake; strobes during a handshake are dropped
    case (s_q.st)
      tqx_pkg::TQX_IDLE: begin
        if (exec_fall && s_q.tx_en) begin
          // trigger driven on the next edge
          s_d.trig_pin.oe = 1'b1;
          s_d.cnt = tqx_pkg::TRIG_HOLD_CYC;
          s_d.st = tqx_pkg::TQX_DRIVE;
          // no internal trigger lines, start now
          s_d.meas_start = ~(s_q.internal_trigger_one | s_q.internal_trigger_two);
        end
      end
      tqx_pkg::TQX_DRIVE: begin
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h01) begin
          s_d.trig_pin.oe = 1'b0;
          s_d.cnt = tqx_pkg::SETTLE_CYC;
          s_d.st = tqx_pkg::TQX_SETTLE;
        end
      end
      tqx_pkg::TQX_SETTLE: begin
        // our own low is still in the synchroniser; let it drain
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h01) begin
          s_d.st = tqx_pkg::TQX_WAIT_REL;
        end
      end
      tqx_pkg::TQX_WAIT_REL: begin
        // wait for every participant to let go
        if (s_q.trig_sync[1]) begin
          s_d.meas_start = s_q.internal_trigger_one | s_q.internal_trigger_two;
          s_d.st = tqx_pkg::TQX_IDLE;
        end
      end
      default: s_d.st = tqx_pkg::TQX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= reset_state();
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.wait_req;
  assign store_o = s_q.store;
  assign meas_start_o = s_q.meas_start;
  assign break_o = s_q.brk;
  assign run_addr_o = s_q.run_addr;
  assign cmb_exec_n_o = s_q.exec_pin;
  assign cmb_trig_n_o = s_q.trig_pin;

  sequence s_strobe_on;
    exec_fall && s_q.tx_en && s_q.st == tqx_pkg::TQX_IDLE;
  endsequence

  sequence s_released;
    ##[1:HOLD_MAX] !s_q.trig_pin.oe;
  endsequence

  a_store_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    store_o |-> $past(sample_valid_i) && $past(hit))
    else $error("store without qualified sample");

  a_mode_reset: assert property (@(posedge clk_i) disable iff (srst_i)
    mode_chg |=> s_q.easy_qual == tqx_pkg::QUAL_ALL &&
                 s_q.term_qual[0] == tqx_pkg::QUAL_ALL &&
                 s_q.term_qual[7] == tqx_pkg::QUAL_ALL)
    else $error("qualifiers not restored on mode change");

  a_exec_ignored: assert property (@(posedge clk_i) disable iff (srst_i)
    exec_fall && !s_q.tx_en && s_q.st == tqx_pkg::TQX_IDLE |=>
      !meas_start_o && !s_q.trig_pin.oe)
    else $error("disabled strobe acted on");

  a_trig_drive: assert property (@(posedge clk_i) disable iff (srst_i)
    s_strobe_on |=> s_q.trig_pin.oe ##0 s_released)
    else $error("trigger not driven then released");

  a_start_direct: assert property (@(posedge clk_i) disable iff (srst_i)
    s_strobe_on ##0 !(s_q.internal_trigger_one || s_q.internal_trigger_two) |=> meas_start_o)
    else $error("direct start missing");

  a_late_start: assert property (@(posedge clk_i) disable iff (srst_i)
    s_q.st == tqx_pkg::TQX_WAIT_REL && s_q.trig_sync[1] &&
    (s_q.internal_trigger_one || s_q.internal_trigger_two) |=> meas_start_o && !$past(s_q.trig_pin.oe))
    else $error("late start missing");

  a_exec_pulse: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(cmb_exec_n_o.oe) |-> cmb_exec_n_o.oe [*1] ##[1:EXEC_MAX]
      !cmb_exec_n_o.oe)
    else $error("execute pulse not ended in time");

  a_break_coord: assert property (@(posedge clk_i) disable iff (srst_i)
    exec_fall && s_q.coord_en |=> break_o)
    else $error("no break on coordinated execute");

  a_bus_answer: assert property (@(posedge clk_i) disable iff (srst_i)
    req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle");

endmodule

// ---- tqx_store_exec_tb_top.sv ----
`timescale 1ns/1ps
module tqx_store_exec_tb_top;
  localparam int PULSE = 4;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [6:0] adr = 7'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic waitreq;
  logic [31:0] smp = 32'h0;
  logic svld = 1'b0;
  logic [2:0] term = 3'h0;
  logic store, mstart, brk;
  logic [31:0] run_addr;
  tqx_pkg::tqx_od_type ex_o, tr_o;
  logic p_strobe = 1'b0;
  logic [7:0] p_hold = 8'h00;
  logic p_ex, p_tr;
  wire ex_line = !p_ex && (ex_o.oe ? ex_o.out : 1'b1);
  wire tr_line = !p_tr && (tr_o.oe ? tr_o.out : 1'b1);
  int fails = 0;
  int samples_checked = 0;
  int n_start, n_brk, n_ex, n_tr;
  logic [31:0] pv [8];
  logic [31:0] pm [8];
  int easy_q, cplx;
  int tq [8];
  logic [31:0] r;

  tqx_store_exec #(.EXEC_PULSE_CYC(PULSE)) u_tqx_store_exec (
    .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(waitreq), .sample_i(smp), .sample_valid_i(svld),
    .seq_term_i(term), .store_o(store), .meas_start_o(mstart),
    .break_o(brk), .run_addr_o(run_addr), .cmb_exec_n_i(ex_line),
    .cmb_exec_n_o(ex_o), .cmb_trig_n_i(tr_line), .cmb_trig_n_o(tr_o));

  tqx_cmb_partner u_tqx_cmb_partner (
    .clk_i(clk_i), .srst_i(srst_i), .strobe_i(p_strobe), .hold_i(p_hold),
    .trig_line_i(tr_line), .exec_oe_o(p_ex), .trig_oe_o(p_tr));

  // 250 MHz clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // event counters for the execute path
  always @(posedge clk_i) begin
    n_start += int'(mstart === 1'b1);
    n_brk += int'(brk === 1'b1);
    n_ex += int'(ex_o.oe === 1'b1);
    n_tr += int'(tr_o.oe === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one avalon access; held until waitrequest is seen low
  task automatic bus(input bit w, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    // only the watchdog ends a wait that never sees an answer
    do begin
      @(posedge clk_i);
    end while (waitreq !== 1'b0);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // mode switch puts every qualifier back to store-all in the model
  task automatic qreset();
    easy_q = 'h100;
    for (int k = 0; k < 8; k++) tq[k] = 'h100;
  endtask

  // random samples against the storage model, one cycle of latency
  task automatic run(input int n);
    bit e;
    int q;
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_i);
      smp <= $urandom;
      svld <= $urandom_range(0, 3) != 0;
      term <= 3'($urandom_range(0, 7));
      #1;
      if (i > 0) chk(store, e);
      q = cplx ? tq[term] : easy_q;
      e = q[8];
      for (int k = 0; k < 8; k++) begin
        if (q[k] && ((smp ^ pv[k]) & pm[k]) == 0) e = 1'b1;
      end
      // an absent sample is never stored, whatever matches
      e = e && svld;
    end
  endtask

  task automatic wait_tr(input bit v);
    int n;
    n = 0;
    while (p_tr !== v && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) chk(1'b1, 1'b0);
  endtask

  // strobe from the far side, after clearing the start, break and trigger counts
  task automatic strobe(input logic [7:0] hold);
    n_start = 0;
    n_brk = 0;
    n_tr = 0;
    p_hold <= hold;
    @(posedge clk_i);
    p_strobe <= 1'b1;
    @(posedge clk_i);
    p_strobe <= 1'b0;
  endtask

  task automatic finish_test();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog, the whole run needs well under 5000 cycles
  initial begin
    #100000;
    fails++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h6f117bdb));
    for (int k = 0; k < 8; k++) begin
      pv[k] = 32'h0;
      pm[k] = 32'h0;
    end
    cplx = 0;
    qreset();
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    bus(0, 7'h00, 0); chk(r, 32'h2);
    bus(0, 7'h08, 0); chk(r, 32'h100);
    bus(0, 7'h3C, 0); chk(r, 32'h100);
    bus(0, 7'h18, 0); chk(r, 32'h0);
    run(40);
    pv[0] = 32'h1;
    pm[0] = 32'h3;
    pv[1] = 32'h2;
    pm[1] = 32'h3;
    for (int k = 0; k < 2; k++) begin
      bus(1, 7'(8'h40 + 8 * k), pv[k]);
      bus(1, 7'(8'h44 + 8 * k), pm[k]);
    end
    easy_q = 'h3;
    bus(1, 7'h08, 32'h3);
    run(150);
    bus(1, 7'h00, 32'h3);
    cplx = 1;
    qreset();
    bus(0, 7'h08, 0); chk(r, 32'h100);
    bus(1, 7'h0C, 32'h2);
    for (int k = 0; k < 8; k++) tq[k] = 'h2;
    bus(1, 7'h28, 32'h1);
    tq[2] = 'h1;
    bus(1, 7'h10, $urandom);
    bus(0, 7'h28, 0); chk(r, 32'h1);
    bus(0, 7'h34, 0); chk(r, 32'h2);
    run(300);
    bus(1, 7'h00, 32'h2);
    cplx = 0;
    qreset();
    bus(0, 7'h28, 0); chk(r, 32'h100);
    run(30);
    bus(1, 7'h14, 32'h0000_2000);
    @(posedge clk_i);
    chk(run_addr, 32'h0000_2000);
    strobe(8'h14);
    wait_tr(1'b1);
    chk(n_start, 1);
    chk(n_tr, 1);
    wait_tr(1'b0);
    repeat (12) @(posedge clk_i);
    chk(n_start, 1);
    bus(1, 7'h00, 32'h16);
    strobe(8'h14);
    wait_tr(1'b1);
    chk(n_start, 0);
    wait_tr(1'b0);
    repeat (12) @(posedge clk_i);
    chk(n_start, 1);
    chk(n_brk, 1);
    bus(1, 7'h00, 32'h0);
    strobe(8'h00);
    repeat (20) @(posedge clk_i);
    chk(n_start, 0);
    chk(n_tr, 0);
    n_ex = 0;
    bus(1, 7'h00, 32'h8);
    repeat (30) @(posedge clk_i);
    chk(n_ex, PULSE);
    chk(n_start, 0);
    bus(1, 7'h00, 32'hE);
    repeat (30) @(posedge clk_i);
    chk(n_start, 1);
    chk(n_brk, 1);
    finish_test();
  end
endmodule
